// ### shared/dsw_defs.svh
// Constants for the deep sleep watchdog
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH

`define DSW_CFG_W          5
`define DSW_CFG_OSC_BIT    4
`define DSW_CFG_PS_MSB     3
`define DSW_CFG_PS_LSB     0
`define DSW_PS_W           4
`define DSW_OSC_XTAL       1'h0
`define DSW_OSC_RC         1'h1
`define DSW_CH_XTAL        0
`define DSW_CH_RC          1
`define DSW_CH_N           2
`define DSW_CNT_W          36
`define DSW_SHIFT_W        6
`define DSW_SHIFT_BASE     6'h06
`define DSW_CNT_ONE        36'h0_0000_0001
`define DSW_CNT_ZERO       36'h0_0000_0000
`define DSW_RC_NOM_HZ      31000
`define DSW_CLK_HZ         200000000

`endif

// ### shared/dsw_pkg.sv
// Types for the deep sleep watchdog
package dsw_pkg;
  typedef enum logic [1:0] {
    DSW_OFF  = 2'b00,
    DSW_RUN  = 2'b01,
    DSW_WAKE = 2'b10
  } dsw_state_t;
endpackage

// ### rtl/dsw_osc_tick.sv
// Oscillator pin synchronisers and rising-edge tick enables
`timescale 1ns/1ps
`include "dsw_defs.svh"
module dsw_osc_tick (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] osc_in,
  output logic      [1:0] tick
);
  import dsw_pkg::*;

  genvar g;
  generate
    for (g = 0; g < `DSW_CH_N; g = g + 1) begin : g_ch
      logic meta_q;
      logic sync_q;
      logic prev_q;
      logic tick_q;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
          tick_q <= 1'b0;
        end else begin
          meta_q <= osc_in[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
          tick_q <= sync_q & ~prev_q;
        end
      end
      assign tick[g] = tick_q;
    end
  endgenerate
endmodule

// ### rtl/dsw_watchdog.sv
// Deep sleep watchdog: clock select, postscaler counter, wake event
//
// Contract
// R1 - When enabled, counts through deep sleep, separate from the ordinary watchdog.
// R2 - Config bit 4 picks secondary crystal or low-power RC as count clock.
// R3 - Config bits 3:0 pick the postscaler, periods about 2.1 ms to 25.7 days.
// R4 - Enabling the watchdog switches on its selected oscillator.
// R5 - Expiry raises a wake-up event out of deep sleep.
// R6 - Low-power RC clock is taken as nominal 31 kHz for periods.
// R7 - Counter and postscaler clear on each entry into deep sleep.
`timescale 1ns/1ps
`include "dsw_defs.svh"
module dsw_watchdog (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [`DSW_CFG_W-1:0]  deep_sleep_config_word,
  input  wire logic                   dsw_enable,
  input  wire logic                   deep_sleep,
  input  wire logic                   secondary_crystal_osc,
  input  wire logic                   low_power_rc_osc,
  output logic                        secondary_osc_enable,
  output logic                        low_power_rc_enable,
  output logic                        dsw_wake,
  output logic                        dsw_running,
  output logic [`DSW_CNT_W-1:0]       dsw_count
);
  import dsw_pkg::*;

  dsw_state_t               state_q;
  dsw_state_t               state_d;
  logic [`DSW_CNT_W-1:0]    cnt_q;
  logic [`DSW_CNT_W-1:0]    cnt_d;
  logic                     sleep_prev_q;
  logic                     xtal_en_q;
  logic                     xtal_en_d;
  logic                     rc_en_q;
  logic                     rc_en_d;
  logic                     wake_q;
  logic                     wake_d;
  logic                     running_q;
  logic                     running_d;
  logic [`DSW_CH_N-1:0]     tick;

  wire                      dsw_clock_select;
  wire [`DSW_PS_W-1:0]      dsw_period_select;
  wire                      tick_sel;
  wire [`DSW_SHIFT_W-1:0]   shamt;
  wire [`DSW_CNT_W-1:0]     limit;
  wire                      sleep_entry;
  wire                      sleep_kept;
  wire                      at_limit;
  wire                      count_step;
  wire                      expire;

  // Pin edges arrive two to three clocks late
  dsw_osc_tick u_tick (
    .clk    (clk),
    .reset  (reset),
    .osc_in ({low_power_rc_osc, secondary_crystal_osc}),
    .tick   (tick)
  );

  // Configuration word fields
  assign dsw_clock_select  = deep_sleep_config_word[`DSW_CFG_OSC_BIT]; // R2
  assign dsw_period_select =
    deep_sleep_config_word[`DSW_CFG_PS_MSB:`DSW_CFG_PS_LSB]; // R3

  // RC ticks are the 31 kHz nominal clock; periods count those ticks
  assign tick_sel = (dsw_clock_select == `DSW_OSC_RC) ? tick[`DSW_CH_RC]
                                                      : tick[`DSW_CH_XTAL]; // R2 R6

  // Period is 2^(6+2*sel) ticks: 64 ticks to 2^36 ticks
  assign shamt = `DSW_SHIFT_BASE + {1'h0, dsw_period_select, 1'h0}; // R3
  // At select 15 the one shifts out and the subtraction wraps to all ones
  assign limit = (`DSW_CNT_ONE << shamt) - `DSW_CNT_ONE; // R3

  // Deep sleep entry and hold, from the power controller
  assign sleep_entry = deep_sleep & ~sleep_prev_q; // R7
  assign sleep_kept  = deep_sleep & dsw_enable; // R1
  // A period select changed in mid-count moves the limit at once
  assign at_limit    = (cnt_q == limit);
  assign count_step  = (state_q == DSW_RUN) && tick_sel; // R1
  assign expire      = count_step && at_limit; // R5

  always_comb begin
    state_d = state_q;
    case (state_q)
      DSW_OFF: begin
        // Enable raised while already asleep waits for the next entry
        if (dsw_enable && sleep_entry) begin
          state_d = DSW_RUN; // R1
        end
      end
      DSW_RUN: begin
        if (!sleep_kept) begin
          state_d = DSW_OFF;
        end else if (expire) begin
          state_d = DSW_WAKE; // R5
        end
      end
      DSW_WAKE: begin
        // Held until the power controller leaves deep sleep or the enable drops
        if (!sleep_kept) begin
          state_d = DSW_OFF;
        end
      end
      default: begin
        state_d = DSW_OFF;
      end
    endcase
  end

  // Count only while running; every other state holds zero
  always_comb begin
    cnt_d = cnt_q;
    case (state_q)
      DSW_RUN: begin
        if (!sleep_kept || expire) begin
          cnt_d = `DSW_CNT_ZERO;
        end else if (tick_sel) begin
          cnt_d = cnt_q + `DSW_CNT_ONE; // R1
        end
      end
      default: begin
        cnt_d = `DSW_CNT_ZERO;
      end
    endcase
    if (sleep_entry) begin
      cnt_d = `DSW_CNT_ZERO; // R7
    end
  end

  // Oscillator enables follow enable and selection, not the sleep state
  assign xtal_en_d = dsw_enable && (dsw_clock_select == `DSW_OSC_XTAL); // R4
  assign rc_en_d   = dsw_enable && (dsw_clock_select == `DSW_OSC_RC); // R4
  // Registered from the next state so it always matches state_q
  assign running_d = (state_d == DSW_RUN);
  assign wake_d    = expire; // R5

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= DSW_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Tick counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= `DSW_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Previous sleep level, for entry detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_prev_q <= 1'h0;
    end else begin
      sleep_prev_q <= deep_sleep;
    end
  end

  // Crystal oscillator enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xtal_en_q <= 1'h0;
    end else begin
      xtal_en_q <= xtal_en_d; // R4
    end
  end

  // RC oscillator enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rc_en_q <= 1'h0;
    end else begin
      rc_en_q <= rc_en_d; // R4
    end
  end

  // Wake is a pulse only; whoever needs it sticky must latch it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= wake_d; // R5
    end
  end

  // Running flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      running_q <= 1'h0;
    end else begin
      running_q <= running_d;
    end
  end

  // Every output comes straight from a register
  assign secondary_osc_enable = xtal_en_q;
  assign low_power_rc_enable  = rc_en_q;
  assign dsw_wake             = wake_q;
  assign dsw_running          = running_q;
  assign dsw_count            = cnt_q;
endmodule

// ### tb/dsw_watchdog_chk.sv
// Port assertions for the deep sleep watchdog
`timescale 1ns/1ps
`include "dsw_defs.svh"
module dsw_chk (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic [`DSW_CFG_W-1:0] deep_sleep_config_word,
  input wire logic                  dsw_enable,
  input wire logic                  deep_sleep,
  input wire logic                  secondary_osc_enable,
  input wire logic                  low_power_rc_enable,
  input wire logic                  dsw_wake,
  input wire logic                  dsw_running,
  input wire logic [`DSW_CNT_W-1:0] dsw_count
);
  wire [`DSW_PS_W-1:0] ps     = deep_sleep_config_word[`DSW_CFG_PS_MSB:`DSW_CFG_PS_LSB];
  wire                 want_s = dsw_enable && !deep_sleep_config_word[`DSW_CFG_OSC_BIT];
  wire                 want_r = dsw_enable && deep_sleep_config_word[`DSW_CFG_OSC_BIT];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  xtal_en_a: assert property (!$past(reset) |-> secondary_osc_enable == $past(want_s))
    else $error("bad crystal enable");
  rc_en_a: assert property (!$past(reset) |-> low_power_rc_enable == $past(want_r))
    else $error("bad rc enable");
  start_run_a: assert property (!$past(reset) && $rose(deep_sleep) && dsw_enable
    && !dsw_running |=> dsw_running && dsw_count == 0) else $error("no clean start");
  abort_clear_a: assert property (dsw_running && !(deep_sleep && dsw_enable)
    |=> !dsw_running && dsw_count == 0) else $error("no abort");
  count_step_a: assert property (dsw_running && $past(dsw_running) |-> dsw_count ==
    $past(dsw_count) || dsw_count == $past(dsw_count) + `DSW_CNT_ONE) else $error("bad step");
  wake_limit_a: assert property (dsw_wake |-> $past(dsw_count) ==
    (`DSW_CNT_ONE << (`DSW_SHIFT_BASE + 2 * $past(ps))) - `DSW_CNT_ONE) else $error("bad limit");
  wake_pulse_a: assert property (dsw_wake |=> !dsw_wake) else $error("long wake");
  wake_stop_a: assert property (dsw_wake |-> $past(dsw_running) && !dsw_running
    && dsw_count == 0) else $error("bad wake end");
endmodule
bind dsw_watchdog dsw_chk chk_u (
  .clk                    (clk),
  .reset                  (reset),
  .deep_sleep_config_word (deep_sleep_config_word),
  .dsw_enable             (dsw_enable),
  .deep_sleep             (deep_sleep),
  .secondary_osc_enable   (secondary_osc_enable),
  .low_power_rc_enable    (low_power_rc_enable),
  .dsw_wake               (dsw_wake),
  .dsw_running            (dsw_running),
  .dsw_count              (dsw_count)
);

// ### tb/tb_top.sv
// Bench for the deep sleep watchdog
`timescale 1ns/1ps
`include "dsw_defs.svh"
module tb_top;
  logic                  clk = 0, reset = 1, en = 0, ds = 0, se, re, wk, rn;
  logic [`DSW_CFG_W-1:0] cfg = 0;
  logic [1:0]            osc = 0, run = 0, ph = 0;
  logic [`DSW_CNT_W-1:0] cnt;
  int                    fail_count = 0, compares = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // Oscillators toggle every 4 cycles, well above the sync limit
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    if (&ph) osc <= osc ^ run;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  dsw_watchdog dut_u (.clk(clk), .reset(reset), .deep_sleep_config_word(cfg),
    .dsw_enable(en), .deep_sleep(ds), .secondary_crystal_osc(osc[0]),
    .low_power_rc_osc(osc[1]), .secondary_osc_enable(se), .low_power_rc_enable(re),
    .dsw_wake(wk), .dsw_running(rn), .dsw_count(cnt));
  task chk(string n, logic [35:0] e, logic [35:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_period(logic sel, logic [3:0] ps);
    int n, l;
    n = 0;
    l = 8 << (6 + 2 * ps);
    @(posedge clk);
    cfg <= {sel, ps};
    en <= 1'h1;
    run <= 2'h1 << sel;
    @(posedge clk);
    #1 chk("enables", {sel, ~sel}, {re, se});
    @(posedge clk) ds <= 1'h1;
    while (wk !== 1'h1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    chk("period", 1'h1, n >= l - 8 && n <= l + 16);
    ds <= 1'h0;
  endtask
  // Only the unselected oscillator runs, so nothing may count
  task t_wrong;
    @(posedge clk);
    cfg <= 5'h10;
    run <= 2'h1;
    // Let a last tick of the stopped RC input drain first
    repeat (8) @(posedge clk);
    ds <= 1'h1;
    repeat (700) @(posedge clk);
    chk("foreign ticks", 36'h0, cnt);
    chk("running", 1'h1, rn);
    ds <= 1'h0;
  endtask
  // Abort on dropped enable, refuse a late enable, then a clean full period
  task t_abort;
    int n, l;
    n = 0;
    l = 8 * 64;
    @(posedge clk);
    cfg <= 5'h00;
    run <= 2'h1;
    repeat (8) @(posedge clk);
    ds <= 1'h1;
    repeat (300) @(posedge clk);
    chk("counting", 1'h1, cnt > 36'h0 && rn);
    en <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk("abort count", 36'h0, cnt);
    chk("abort run", 1'h0, rn);
    chk("enables off", 2'h0, {re, se});
    @(posedge clk) en <= 1'h1;
    repeat (100) @(posedge clk);
    chk("late enable", 1'h0, rn);
    ds <= 1'h0;
    @(posedge clk) ds <= 1'h1;
    repeat (2) @(posedge clk);
    chk("entry count", 36'h0, cnt);
    chk("entry run", 1'h1, rn);
    while (wk !== 1'h1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk("full period", 1'h1, n >= l - 8 && n <= l + 16);
    ds <= 1'h0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 3; p++)
        t_period(s[0], p[3:0]);
    t_wrong;
    t_abort;
    summarize;
  end
endmodule
